// ===== shared/uls_defines.vh
// register map, bit positions and reset values of the line status block
`ifndef ULS_DEFINES_VH
`define ULS_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ULS_OFF_STAT 8'h00
`define ULS_OFF_CTRL 8'h04
`define ULS_OFF_EVT 8'h08
`define ULS_OFF_MASK 8'h0C

// ----------------------------------------
// line status bit positions
// ----------------------------------------
`define ULS_STAT_DR 0
`define ULS_STAT_OE 1
`define ULS_STAT_PE 2
`define ULS_STAT_FE 3
`define ULS_STAT_BI 4
`define ULS_STAT_HEMPTY 5
`define ULS_STAT_TEMT 6
`define ULS_STAT_FERR 7

// ----------------------------------------
// control bits and reset values
// ----------------------------------------
`define ULS_CTRL_FIFO 0
`define ULS_CTRL_THRIE 1
`define ULS_CTRL_PAREN 2
`define ULS_CTRL_RST 3'h0
`define ULS_MASK_RST 6'h00

// ----------------------------------------
// receive error fifo
// ----------------------------------------
`define ULS_DEPTH 7'h40
`define ULS_PTR_W 6
`define ULS_CNT_W 7

`endif

// ===== src/uls_err_fifo.v
// receive fifo of per-character error flags
`timescale 1ns/1ps
`default_nettype none
`include "uls_defines.vh"

module uls_err_fifo (
    input wire core_clk_i,
    input wire reset_i,
    input wire push_i,
    input wire [2:0] flags_i,
    input wire pop_i,
    input wire single_i,
    output wire [2:0] head_o,
    output wire [`ULS_CNT_W-1:0] count_o,
    output wire full_o
);

    reg [2:0] mem [0:63];
    reg [`ULS_PTR_W-1:0] wr_ptr_q;
    reg [`ULS_PTR_W-1:0] rd_ptr_q;
    reg [`ULS_CNT_W-1:0] cnt_q;
    wire do_push;
    wire do_pop;

    // outside fifo mode the stage behaves as a one-word holding register
    assign full_o = single_i ? (cnt_q != 7'h00) : (cnt_q == `ULS_DEPTH);
    assign do_push = push_i & ~full_o;
    assign do_pop = pop_i & (cnt_q != 7'h00);
    assign head_o = mem[rd_ptr_q];
    assign count_o = cnt_q;

    always @(posedge core_clk_i) begin
        if (do_push) begin
            mem[wr_ptr_q] <= flags_i;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_ptr_q <= 6'h00;
            rd_ptr_q <= 6'h00;
            cnt_q <= 7'h00;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + 6'h01;
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + 6'h01;
            end
            if (do_push & ~do_pop) begin
                cnt_q <= cnt_q + 7'h01;
            end else if (do_pop & ~do_push) begin
                cnt_q <= cnt_q - 7'h01;
            end
        end
    end

endmodule
`default_nettype wire

// ===== src/uls_line_status.v
// line status logic of a uart with ahb-lite register access
`timescale 1ns/1ps
`default_nettype none
`include "uls_defines.vh"

// Summary of operation
// - fifo mode: bit 7 sets when any character queued in receive fifo has an error
// - reading line status clears bit 7
// - non-fifo: bit 6 high only when holding and shift stages are empty
// - fifo mode: bit 6 high only when tx fifo and shift stage empty
// - non-fifo: bit 5 sets on move to shift stage, clears on cpu load
// - interrupt request while bit 5 set and its enable is on
// - fifo mode: bit 5 follows tx fifo empty, clears on any write
// - break flagged when line low for a whole character frame
// - fifo mode: only one break character queued per break condition
// - bit 3 framing error when stop bit sampled low
// - fifo mode: framing status shown only for the head character
// - parity error flagged, in fifo mode for the head character
// - bit 1 overrun when character completes with fifo full, fifo kept
// - bit 0 high while any received character waits
module uls_line_status (
    input wire core_clk_i,
    input wire reset_i,
    // ahb-lite slave
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output reg [31:0] hrdata_o,
    output reg hreadyout_o,
    output reg hresp_o,
    // transmit datapath
    input wire tx_wr_i,
    input wire tx_move_i,
    input wire tx_shift_busy_i,
    input wire tx_fifo_empty_i,
    // receive datapath
    input wire rxd_i,
    input wire rx_done_i,
    input wire [7:0] rx_data_i,
    input wire rx_par_bit_i,
    input wire rx_par_err_i,
    input wire rx_stop_i,
    input wire rx_read_i,
    output reg rx_push_o,
    output reg data_ready_o,
    output reg hold_irq_o,
    output reg irq_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [2:0] ctrl_q;
    reg [5:0] mask_q;
    reg [5:0] evt_q;
    reg [5:0] evt_d;
    reg thre_q;
    reg thre_d;
    reg temt_q;
    reg temt_d;
    reg oe_q;
    reg [2:0] lerr_q;
    reg [2:0] lerr_d;
    reg ferr_q;
    reg brk_hold_q;
    reg head_load_q;
    reg [`ULS_CNT_W-1:0] err_cnt_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    wire fifo_en;
    wire par_en;
    wire [2:0] head;
    wire [`ULS_CNT_W-1:0] count;
    wire full;

    assign fifo_en = ctrl_q[`ULS_CTRL_FIFO];
    assign par_en = ctrl_q[`ULS_CTRL_PAREN];

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire addr_ph;
    wire rd_ph;
    wire stat_rd;
    wire [7:0] stat_val;
    wire wr_ctrl;
    wire wr_evt;
    wire wr_mask;

    assign addr_ph = hsel_i & htrans_i[1] & hready_i;
    assign rd_ph = addr_ph & ~hwrite_i;
    assign stat_rd = rd_ph & (haddr_i[7:0] == `ULS_OFF_STAT);
    assign wr_ctrl = wr_pend_q & (wr_addr_q == `ULS_OFF_CTRL);
    assign wr_evt = wr_pend_q & (wr_addr_q == `ULS_OFF_EVT);
    assign wr_mask = wr_pend_q & (wr_addr_q == `ULS_OFF_MASK);

    // ----------------------------------------
    // receive side
    // ----------------------------------------
    wire is_break;
    wire drop;
    wire push;
    wire pop;
    wire [2:0] flags;
    wire push_err;
    wire pop_err;
    wire new_head;

    // line low through start, data, parity and stop periods
    assign is_break = rx_done_i & (rx_data_i == 8'h00) &
        ~(par_en & rx_par_bit_i) & ~rx_stop_i;
    // in fifo mode, further all-zero frames of the same break are discarded
    assign drop = fifo_en & brk_hold_q & is_break;
    assign push = rx_done_i & ~drop & ~full;
    assign pop = rx_read_i & (count != 7'h00);
    assign flags = {is_break, ~rx_stop_i,
        par_en & rx_par_err_i};
    assign push_err = push & (flags != 3'h0);
    assign pop_err = pop & (head != 3'h0);
    // a pop leaves the next character at the head one cycle later
    assign new_head = pop & ((count > 7'h01) | push);

    uls_err_fifo u_fifo (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .push_i(push),
        .flags_i(flags),
        .pop_i(pop),
        .single_i(~fifo_en),
        .head_o(head),
        .count_o(count),
        .full_o(full)
    );

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            brk_hold_q <= 1'b0;
        end else if (is_break & ~drop) begin
            brk_hold_q <= 1'b1;
        end else if (rxd_i) begin
            brk_hold_q <= 1'b0;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            err_cnt_q <= 7'h00;
        end else if (push_err & ~pop_err) begin
            err_cnt_q <= err_cnt_q + 7'h01;
        end else if (pop_err & ~push_err) begin
            err_cnt_q <= err_cnt_q - 7'h01;
        end
    end

    // ----------------------------------------
    // line status error bits
    // ----------------------------------------
    // head flags appear as the character becomes head; a pop in fifo
    // mode withdraws them, a status read clears them
    always @* begin
        lerr_d = lerr_q;
        if (stat_rd | (fifo_en & pop)) begin
            lerr_d = 3'h0;
        end
        if (push & (count == 7'h00)) begin
            lerr_d = lerr_d | flags;
        end
        // head output trails the read pointer, so load it a cycle late
        if (head_load_q & ~pop) begin
            lerr_d = lerr_d | head;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            lerr_q <= 3'h0;
            head_load_q <= 1'b0;
            oe_q <= 1'b0;
            ferr_q <= 1'b0;
        end else begin
            lerr_q <= lerr_d;
            head_load_q <= new_head;
            // overrun sets over a same-cycle read clear
            if (rx_done_i & ~drop & full) begin
                oe_q <= 1'b1;
            end else if (stat_rd) begin
                oe_q <= 1'b0;
            end
            if (fifo_en & (push_err |
                    ((err_cnt_q != 7'h00) & ~stat_rd & ferr_q))) begin
                ferr_q <= 1'b1;
            end else if (stat_rd | (err_cnt_q == 7'h00)) begin
                ferr_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // transmit side
    // ----------------------------------------
    always @* begin
        if (fifo_en) begin
            thre_d = tx_fifo_empty_i & ~tx_wr_i;
            temt_d = tx_fifo_empty_i & ~tx_wr_i &
                ~tx_shift_busy_i;
        end else begin
            // a load in the same cycle as the move refills the stage
            thre_d = (thre_q | tx_move_i) & ~tx_wr_i;
            temt_d = thre_d & ~tx_shift_busy_i &
                ~tx_move_i;
        end
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            thre_q <= 1'b1;
            temt_q <= 1'b1;
        end else begin
            thre_q <= thre_d;
            temt_q <= temt_d;
        end
    end

    assign stat_val = {ferr_q, temt_q, thre_q, lerr_q, oe_q,
        data_ready_o};

    // ----------------------------------------
    // event status and interrupt
    // ----------------------------------------
    wire [5:0] evt_set;

    assign evt_set = {pop & ~data_ready_o ? 1'b0 : push,
        thre_d & ~thre_q, lerr_d & ~lerr_q,
        rx_done_i & ~drop & full};

    // write-one-to-clear; a new event in the same cycle wins
    always @* begin
        evt_d = evt_q;
        if (wr_evt) begin
            evt_d = evt_q & ~hwdata_i[5:0];
        end
        evt_d = evt_d | evt_set;
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            evt_q <= 6'h00;
            mask_q <= `ULS_MASK_RST;
            ctrl_q <= `ULS_CTRL_RST;
            irq_o <= 1'b0;
            hold_irq_o <= 1'b0;
        end else begin
            evt_q <= evt_d;
            if (wr_mask) begin
                mask_q <= hwdata_i[5:0];
            end
            if (wr_ctrl) begin
                ctrl_q <= hwdata_i[2:0];
            end
            irq_o <= |(evt_d & mask_q);
            hold_irq_o <= thre_d & ctrl_q[`ULS_CTRL_THRIE];
        end
    end

    // ----------------------------------------
    // datapath handshakes
    // ----------------------------------------
    always @(posedge core_clk_i) begin
        if (reset_i) begin
            rx_push_o <= 1'b0;
            data_ready_o <= 1'b0;
        end else begin
            rx_push_o <= push;
            // waiting characters, counting this cycle's push and pop
            data_ready_o <= (count > 7'h01) |
                ((count == 7'h01) & ~pop) | push;
        end
    end

    // ----------------------------------------
    // ahb-lite slave: zero wait states, always okay
    // ----------------------------------------
    reg [31:0] rdata_d;

    always @* begin
        case (haddr_i[7:0])
            `ULS_OFF_STAT: rdata_d = {24'h00_0000, stat_val};
            `ULS_OFF_CTRL: rdata_d = {29'h0000_0000, ctrl_q};
            `ULS_OFF_EVT: rdata_d = {26'h000_0000, evt_q};
            `ULS_OFF_MASK: rdata_d = {26'h000_0000, mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always @(posedge core_clk_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            wr_pend_q <= addr_ph & hwrite_i;
            if (addr_ph) begin
                wr_addr_q <= haddr_i[7:0];
            end
            if (rd_ph) begin
                // value sampled before the read-clear takes effect
                hrdata_o <= rdata_d;
            end
        end
    end

endmodule
`default_nettype wire

// ===== bench/uls_host_model.sv
// host cpu model: ahb-lite master issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module uls_host_model (
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [31:0] hwdata_o
);
    initial {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
    // no latency assumed: every phase waits for hready
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel_o <= 1'h1;
        haddr_o <= {24'h00_0000, a};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        @(posedge clk_i);
        while (hready_i !== 1'h1)
            @(posedge clk_i);
        hsel_o <= 1'h0;
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        @(posedge clk_i);
        while (hready_i !== 1'h1)
            @(posedge clk_i);
        rd = hrdata_i;
    endtask
endmodule
`default_nettype wire

// ===== bench/uls_line_status_assertions.sv
// concurrent checks on the line status block ports
`timescale 1ns/1ps
`default_nettype none
module uls_line_status_assertions (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic tx_wr_i,
    input wire logic tx_move_i,
    input wire logic rx_done_i,
    input wire logic rx_stop_i,
    input wire logic rx_read_i,
    input wire logic rx_push_o,
    input wire logic data_ready_o,
    input wire logic hold_irq_o,
    input wire logic irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // status reads, received characters, transmit loads and reset
    // ----------------------------------------
    sequence s_ls_read;
        hsel_i && htrans_i[1] && hready_i && !hwrite_i
            && haddr_i[7:0] == 8'h00;
    endsequence
    sequence s_quiet;
        !rx_done_i && !rx_read_i && !$past(rx_read_i);
    endsequence
    sequence s_err_frame;
        rx_done_i && !rx_stop_i && !data_ready_o;
    endsequence
    a_rx_sets_ready: assert property (rx_done_i |=> data_ready_o)
        else $error("no data ready after a character");
    a_ready_needs_read: assert property (
        $fell(data_ready_o) |-> $past(rx_read_i))
        else $error("data ready fell without a read");
    a_push_has_cause: assert property (
        rx_push_o |-> $past(rx_done_i))
        else $error("push without a character");
    a_push_when_room: assert property (
        rx_done_i && !data_ready_o |=> rx_push_o)
        else $error("character not stored with room");
    a_load_drops_irq: assert property (
        tx_wr_i && !tx_move_i |-> ##[1:2] !hold_irq_o)
        else $error("holding irq stayed after a load");
    // second read must see the clear done by the first
    a_read_clears_err: assert property (
        s_ls_read ##0 s_quiet ##1 s_quiet ##1 s_ls_read
            |=> (hrdata_o & 32'h0000_009E) == 32'h0000_0000)
        else $error("error bits survived a status read");
    a_frame_err_shown: assert property (
        s_err_frame ##2 s_ls_read |=> hrdata_o[3])
        else $error("framing error not reported");
    a_reset_quiet: assert property (
        $fell(reset_i) |-> !data_ready_o && !irq_o && !hold_irq_o)
        else $error("outputs active after reset");
endmodule
bind uls_line_status uls_line_status_assertions chk_u (
    .core_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hrdata_o, .tx_wr_i, .tx_move_i, .rx_done_i, .rx_stop_i,
    .rx_read_i, .rx_push_o, .data_ready_o, .hold_irq_o, .irq_o
);
`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the line status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic core_clk_i, reset_i, hsel_i, hwrite_i, tx_wr_i, tx_move_i;
    logic tx_shift_busy_i, tx_fifo_empty_i, rxd_i, rx_done_i;
    logic rx_par_bit_i, rx_par_err_i, rx_stop_i, rx_read_i;
    logic [1:0] htrans_i;
    logic [2:0] hsize_i;
    logic [7:0] rx_data_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic hreadyout_o, hresp_o, rx_push_o, data_ready_o, hold_irq_o, irq_o;
    int n_errors = 0;
    int check_count = 0;
    int n_push = 0;
    logic [31:0] err_exp [4] = '{32'h0000_0069, 32'h0000_0065,
        32'h0000_0079, 32'h0000_0069};

    uls_line_status dut_u (
        .core_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
        .hreadyout_o, .hresp_o, .tx_wr_i, .tx_move_i, .tx_shift_busy_i,
        .tx_fifo_empty_i, .rxd_i, .rx_done_i, .rx_data_i, .rx_par_bit_i,
        .rx_par_err_i, .rx_stop_i, .rx_read_i, .rx_push_o, .data_ready_o,
        .hold_irq_o, .irq_o
    );
    uls_host_model host_u (
        .clk_i(core_clk_i), .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
        .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i),
        .hwrite_o(hwrite_i), .hwdata_o(hwdata_i)
    );
    // ----------------------------------------
    // clock, push counter, watchdog
    // ----------------------------------------
    initial begin
        core_clk_i = 1'h0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (rx_push_o === 1'h1)
            n_push++;
    end
    initial begin
        repeat (4000) @(posedge core_clk_i);
        n_errors++;
        stop_test();
    end
    task automatic stop_test;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bit_chk(input string nm, input logic s, input logic e);
        check(nm, {31'h0, s}, {31'h0, e});
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        host_u.xfer(1'h0, a, 32'h0000_0000, r);
        check($sformatf("reg_%h", a), r, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        host_u.xfer(1'h1, a, d, r);
    endtask
    // ends 1 ns past the edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic txp(input logic w, input logic m);
        tx_wr_i <= w;
        tx_move_i <= m;
        @(posedge core_clk_i);
        tx_wr_i <= 1'h0;
        tx_move_i <= 1'h0;
        tick(1);
    endtask
    task automatic rx(input logic s, input logic p, input logic [7:0] d);
        rx_done_i <= 1'h1;
        rx_stop_i <= s;
        rx_par_err_i <= p;
        rx_data_i <= d;
        @(posedge core_clk_i);
        rx_done_i <= 1'h0;
        tick(1);
    endtask
    task automatic pop;
        rx_read_i <= 1'h1;
        @(posedge core_clk_i);
        rx_read_i <= 1'h0;
        tick(1);
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        reset_i = 1'h1;
        {tx_wr_i, tx_move_i, tx_shift_busy_i, rx_done_i} = 4'h0;
        {rx_par_bit_i, rx_par_err_i, rx_stop_i, rx_read_i} = 4'h0;
        {tx_fifo_empty_i, rxd_i} = 2'h3;
        rx_data_i = 8'h00;
        hsize_i = 3'h2;
        repeat (6) @(posedge core_clk_i);
        reset_i <= 1'h0;
        tick(1);
        rd_chk(8'h00, 32'h0000_0060);
        rd_chk(8'h10, 32'h0000_0000);
        tick(0);
        bit_chk("data_ready", data_ready_o, 1'h0);
        bit_chk("hresp", hresp_o, 1'h0);
        $display("reset test done");
        wr(8'h04, 32'h0000_0002);
        tick(2);
        bit_chk("hold_irq", hold_irq_o, 1'h1);
        txp(1'h1, 1'h0);
        bit_chk("hold_irq", hold_irq_o, 1'h0);
        rd_chk(8'h00, 32'h0000_0000);
        tx_shift_busy_i <= 1'h1;
        txp(1'h0, 1'h1);
        rd_chk(8'h00, 32'h0000_0020);
        tx_shift_busy_i <= 1'h0;
        tick(1);
        rd_chk(8'h00, 32'h0000_0060);
        wr(8'h04, 32'h0000_0001);
        tx_fifo_empty_i <= 1'h0;
        txp(1'h1, 1'h0);
        rd_chk(8'h00, 32'h0000_0000);
        tx_fifo_empty_i <= 1'h1;
        tick(1);
        rd_chk(8'h00, 32'h0000_0060);
        $display("transmit test done");
        wr(8'h04, 32'h0000_0004);
        // last pass: high parity bit keeps an all-zero frame from a break
        for (int k = 0; k < 4; k++) begin
            rx_par_bit_i <= k == 3;
            rx(k == 1, k == 1, k >= 2 ? 8'h00 : 8'h55);
            rd_chk(8'h00, err_exp[k]);
            pop();
            rd_chk(8'h00, 32'h0000_0060);
        end
        wr(8'h08, 32'h0000_003F);
        wr(8'h0C, 32'h0000_0021);
        rx(1'h1, 1'h0, 8'h5A);
        rx(1'h1, 1'h0, 8'hA5);
        bit_chk("irq", irq_o, 1'h1);
        rd_chk(8'h00, 32'h0000_0063);
        rd_chk(8'h00, 32'h0000_0061);
        rd_chk(8'h08, 32'h0000_0021);
        wr(8'h0C, 32'h0000_0000);
        tick(1);
        bit_chk("irq", irq_o, 1'h0);
        wr(8'h08, 32'h0000_003F);
        rd_chk(8'h08, 32'h0000_0000);
        pop();
        bit_chk("data_ready", data_ready_o, 1'h0);
        $display("receive test done");
        wr(8'h04, 32'h0000_0001);
        rx(1'h1, 1'h0, 8'h11);
        rxd_i <= 1'h0;
        rx(1'h0, 1'h0, 8'h00);
        rx(1'h0, 1'h0, 8'h00);
        rxd_i <= 1'h1;
        rd_chk(8'h00, 32'h0000_00E1);
        pop();
        rd_chk(8'h00, 32'h0000_0079);
        pop();
        rd_chk(8'h00, 32'h0000_0060);
        check("pushes", n_push, 7);
        $display("fifo test done");
        stop_test();
    end
endmodule
`default_nettype wire
